/* pkg/dci_pkg.sv */
// Shared constants and carriers for the disk channel host controller
package dci_pkg;
  // Software register indices
  localparam logic [3:0] REG_TAG   = 4'h0;
  localparam logic [3:0] REG_ADRC  = 4'h1;
  localparam logic [3:0] REG_WDATA = 4'h2;
  localparam logic [3:0] REG_RDATA = 4'h3;
  localparam logic [3:0] REG_STAT  = 4'h4;
  localparam logic [3:0] REG_ENG   = 4'h5;
  // Engine register bit positions
  localparam int ENG_ARM  = 0;
  localparam int ENG_RVAL = 1;
  localparam int ENG_WPND = 2;
  localparam int ENG_MISS = 3;
  localparam int ENG_TMO  = 4;
  // Address/control word bit of the one-shot flag reset
  localparam int ADRC_RSTF = 8;
  // Values after reset
  localparam logic [15:0] TAG_RST  = 16'h0000;
  localparam logic [15:0] ADRC_RST = 16'h0000;
  localparam logic [15:0] ONES     = 16'hffff;
  // Timing
  localparam int CLK_NS      = 40;
  localparam int FLAG_WIN_NS = 6200;
  localparam int FLAG_WIN_CYC = FLAG_WIN_NS / CLK_NS;
  localparam int CNT_W = 9;
  localparam logic [CNT_W-1:0] TMO_CYC  = CNT_W'(3 * FLAG_WIN_CYC);
  localparam logic [CNT_W-1:0] RSTF_CYC = 9'h002;
  // Tag select word
  typedef struct packed {
    logic       sector_sel;
    logic       control_sel;
    logic       diff_sel;
    logic       head_sel;
    logic [1:0] unused_hi;
    logic [1:0] chan_sw;
    logic [7:0] unused_lo;
  } dci_tag_s;
  // Address/control word
  typedef struct packed {
    logic [2:0] unit_sel;
    logic       zeros_search;
    logic       write;
    logic       hold_index;
    logic       hold_sector;
    logic       reset_flag;
    logic [7:0] ac;
  } dci_adrc_s;
  // Unit status word
  typedef struct packed {
    logic       fault;
    logic       on_sector;
    logic       on_cyl;
    logic       seek_err;
    logic       ready;
    logic       index_mark;
    logic       sector_mark;
    logic       flag;
    logic [7:0] selected;
  } dci_stat_s;
  // Word engine states, Gray along the path
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_ACK  = 2'b11,
    ST_DROP = 2'b10
  } dci_state_e;
endpackage : dci_pkg

/* src/dci_host.sv */
// Host controller driving the disk interface channel words
//
// Function
// - Channel switch bits both held clear to route disk channel six.
// - Head select tag means address bits 0-3 carry head address.
// - Difference select tag means address bits carry cylinder difference.
// - Control select tag means address bits carry control information.
// - Sector select tag means address bits 0-3 carry sector address.
// - Hold-sector-mark kept zero to let sector mark clear; the host passes bit 9 as software writes it.
// - Hold-index-mark kept zero to let index mark clear; the host passes bit 10 as software writes it.
// - Zeros search set during tag read; flag waits for sync bit; the host passes bit 12 as software writes it.
// - Three-bit unit code selects unit and is held steady.
// - Host holds all output data bits at one during reads.
// - Flag sets per word, self-clears after 6.2 us; transfer within.
//
// The implementer's own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/100ps
module dci_host (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        resetn,
  // Software register port
  input  wire logic [3:0]  sw_addr,
  input  wire logic [15:0] sw_wdata,
  input  wire logic        sw_wr,
  input  wire logic        sw_rd,
  output logic      [15:0] sw_rdata,
  // Output channels to the interface
  output logic      [15:0] tag_select_output_channel,
  output logic      [15:0] address_control_output_channel,
  output logic      [15:0] disk_data_output_channel,
  // Input channels from the interface
  input  wire logic [15:0] disk_status_input_channel,
  input  wire logic [15:0] disk_data_input_channel
);

  // Stable value once the last two stages agree
  function automatic logic [15:0] stab(
    input logic [15:0] b,
    input logic [15:0] c,
    input logic [15:0] q
  );
    logic [15:0] r;
    r = q;
    for (int i = 0; i < 16; i++)
    begin
      if (b[i] == c[i])
      begin
        r[i] = c[i];
      end
    end
    return r;
  endfunction : stab

  // Reset release through two flops
  logic rst_a_r;
  logic rst_n;
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      rst_a_r <= 1'b0;
      rst_n   <= 1'b0;
    end
    else
    begin
      rst_a_r <= 1'b1;
      rst_n   <= rst_a_r;
    end
  end

  // Three-stage input synchronisers; stage one feeds stage two only
  logic [15:0] st1_r, st2_r, st3_r, stq_r;
  logic [15:0] dt1_r, dt2_r, dt3_r, dtq_r;
  logic [15:0] stq_nxt, dtq_nxt;
  always_comb
  begin
    stq_nxt = stab(st2_r, st3_r, stq_r);
    dtq_nxt = stab(dt2_r, dt3_r, dtq_r);
  end
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st1_r <= 16'h0000;
      st2_r <= 16'h0000;
      st3_r <= 16'h0000;
      stq_r <= 16'h0000;
      dt1_r <= 16'h0000;
      dt2_r <= 16'h0000;
      dt3_r <= 16'h0000;
      dtq_r <= 16'h0000;
    end
    else
    begin
      st1_r <= disk_status_input_channel;
      st2_r <= st1_r;
      st3_r <= st2_r;
      stq_r <= stq_nxt;
      dt1_r <= disk_data_input_channel;
      dt2_r <= dt1_r;
      dt3_r <= dt2_r;
      dtq_r <= dtq_nxt;
    end
  end

  dci_pkg::dci_stat_s stat;
  assign stat = dci_pkg::dci_stat_s'(stq_r);

  // Software-held words and engine state
  dci_pkg::dci_tag_s   tag_r, tag_nxt;
  dci_pkg::dci_adrc_s  adrc_r, adrc_nxt;
  dci_pkg::dci_state_e st_r, st_nxt;
  logic [15:0] wdata_r, wdata_nxt;
  logic [15:0] rdata_r, rdata_nxt;
  logic [15:0] dout_r, dout_nxt;
  logic [15:0] rd_r, rd_nxt;
  logic [dci_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
  logic arm_r, arm_nxt;
  logic rval_r, rval_nxt;
  logic wpnd_r, wpnd_nxt;
  logic miss_r, miss_nxt;
  logic tmo_r, tmo_nxt;
  logic rstf_r, rstf_nxt;
  logic wr_tag, wr_adrc, wr_wd, wr_eng, rd_rdata, xfer;

  // Decoded software strobes
  assign wr_tag   = sw_wr && (sw_addr == dci_pkg::REG_TAG);
  assign wr_adrc  = sw_wr && (sw_addr == dci_pkg::REG_ADRC);
  assign wr_wd    = sw_wr && (sw_addr == dci_pkg::REG_WDATA);
  assign wr_eng   = sw_wr && (sw_addr == dci_pkg::REG_ENG);
  assign rd_rdata = sw_rd && (sw_addr == dci_pkg::REG_RDATA);
  // A word moves when the flag is seen while waiting
  assign xfer = (st_r == dci_pkg::ST_WAIT) && arm_r && stat.flag;

  // Next state of registers and word engine
  always_comb
  begin
    tag_nxt   = tag_r;
    adrc_nxt  = adrc_r;
    st_nxt    = st_r;
    wdata_nxt = wdata_r;
    rdata_nxt = rdata_r;
    dout_nxt  = dout_r;
    cnt_nxt   = cnt_r;
    arm_nxt   = arm_r;
    rval_nxt  = rval_r;
    wpnd_nxt  = wpnd_r;
    miss_nxt  = miss_r;
    tmo_nxt   = tmo_r;
    rstf_nxt  = 1'b0;
    rd_nxt    = 16'h0000;
    // Tag word; channel switch forced clear
    if (wr_tag)
    begin
      tag_nxt = dci_pkg::dci_tag_s'(sw_wdata);
    end
    tag_nxt.chan_sw   = 2'b00;
    tag_nxt.unused_hi = 2'b00;
    tag_nxt.unused_lo = 8'h00;
    // Address/control word; flag reset is a one-shot, never stored
    if (wr_adrc)
    begin
      adrc_nxt = dci_pkg::dci_adrc_s'(sw_wdata);
      rstf_nxt = sw_wdata[dci_pkg::ADRC_RSTF];
    end
    adrc_nxt.reset_flag = 1'b0;
    // Engine register: arm, and write-one-to-clear of errors
    if (wr_eng)
    begin
      arm_nxt = sw_wdata[dci_pkg::ENG_ARM];
      if (sw_wdata[dci_pkg::ENG_MISS])
      begin
        miss_nxt = 1'b0;
      end
      if (sw_wdata[dci_pkg::ENG_TMO])
      begin
        tmo_nxt = 1'b0;
      end
    end
    if (rd_rdata)
    begin
      rval_nxt = 1'b0;
    end
    if (wr_wd)
    begin
      wdata_nxt = sw_wdata;
    end
    // Word engine; sets placed after clears so sets win, except arm, which a timeout clears after a software write
    case (st_r)
      dci_pkg::ST_IDLE:
      begin
        cnt_nxt = '0;
        if (arm_r)
        begin
          st_nxt = dci_pkg::ST_WAIT;
        end
      end
      dci_pkg::ST_WAIT:
      begin
        if (!arm_r)
        begin
          st_nxt = dci_pkg::ST_IDLE;
        end
        else if (xfer)
        begin
          cnt_nxt = '0;
          st_nxt  = dci_pkg::ST_ACK;
          if (adrc_r.write)
          begin
            dout_nxt = wdata_r;
            miss_nxt = miss_nxt || !wpnd_r;
            wpnd_nxt = 1'b0;
          end
          else
          begin
            rdata_nxt = dtq_r;
            miss_nxt  = miss_nxt || rval_r;
            rval_nxt  = 1'b1;
          end
        end
        else if (cnt_r == dci_pkg::TMO_CYC)
        begin
          tmo_nxt = 1'b1;
          arm_nxt = 1'b0;
          st_nxt  = dci_pkg::ST_IDLE;
        end
        else
        begin
          cnt_nxt = cnt_r + 1'b1;
        end
      end
      dci_pkg::ST_ACK:
      begin
        rstf_nxt = 1'b1;
        cnt_nxt  = cnt_r + 1'b1;
        if (cnt_r == dci_pkg::RSTF_CYC - 1'b1)
        begin
          cnt_nxt = '0;
          st_nxt  = dci_pkg::ST_DROP;
        end
      end
      dci_pkg::ST_DROP:
      begin
        // Flag must be seen low before the next word counts
        if (!stat.flag)
        begin
          st_nxt = arm_r ? dci_pkg::ST_WAIT : dci_pkg::ST_IDLE;
        end
      end
      default:
      begin
        st_nxt = dci_pkg::ST_IDLE;
      end
    endcase
    if (wr_wd)
    begin
      wpnd_nxt = 1'b1;
    end
    // Output data stays all ones whenever not writing
    if (!adrc_r.write)
    begin
      dout_nxt = dci_pkg::ONES;
    end
    // Read mux, answer in the next cycle
    if (sw_rd)
    begin
      case (sw_addr)
        dci_pkg::REG_TAG:   rd_nxt = tag_r;
        dci_pkg::REG_ADRC:  rd_nxt = adrc_r;
        dci_pkg::REG_WDATA: rd_nxt = wdata_r;
        dci_pkg::REG_RDATA: rd_nxt = rdata_r;
        dci_pkg::REG_STAT:  rd_nxt = stq_r;
        dci_pkg::REG_ENG:
        begin
          rd_nxt[dci_pkg::ENG_ARM]  = arm_r;
          rd_nxt[dci_pkg::ENG_RVAL] = rval_r;
          rd_nxt[dci_pkg::ENG_WPND] = wpnd_r;
          rd_nxt[dci_pkg::ENG_MISS] = miss_r;
          rd_nxt[dci_pkg::ENG_TMO]  = tmo_r;
        end
        default: rd_nxt = 16'h0000;
      endcase
    end
  end

  // Register everything
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tag_r   <= dci_pkg::TAG_RST;
      adrc_r  <= dci_pkg::ADRC_RST;
      st_r    <= dci_pkg::ST_IDLE;
      wdata_r <= dci_pkg::ONES;
      rdata_r <= 16'h0000;
      dout_r  <= dci_pkg::ONES;
      rd_r    <= 16'h0000;
      cnt_r   <= '0;
      arm_r   <= 1'b0;
      rval_r  <= 1'b0;
      wpnd_r  <= 1'b0;
      miss_r  <= 1'b0;
      tmo_r   <= 1'b0;
      rstf_r  <= 1'b0;
    end
    else
    begin
      tag_r   <= tag_nxt;
      adrc_r  <= adrc_nxt;
      st_r    <= st_nxt;
      wdata_r <= wdata_nxt;
      rdata_r <= rdata_nxt;
      dout_r  <= dout_nxt;
      rd_r    <= rd_nxt;
      cnt_r   <= cnt_nxt;
      arm_r   <= arm_nxt;
      rval_r  <= rval_nxt;
      wpnd_r  <= wpnd_nxt;
      miss_r  <= miss_nxt;
      tmo_r   <= tmo_nxt;
      rstf_r  <= rstf_nxt;
    end
  end

  // Channel outputs, all from flops
  always_comb
  begin
    address_control_output_channel = adrc_r;
    address_control_output_channel[dci_pkg::ADRC_RSTF] = rstf_r;
  end
  assign tag_select_output_channel = tag_r;
  assign disk_data_output_channel  = dout_r;
  assign sw_rdata                  = rd_r;

endmodule : dci_host

/* verification/dci_disk_model.sv */
// Behavioural model of the disk interface and its units
`timescale 1ns/100ps
module dci_disk_model #(
  parameter logic [2:0] UNIT_OK  = 3'h5,
  parameter int         FLAG_CYC = 155
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        resetn,
  // Host channels
  input  wire logic [15:0] adrc,
  input  wire logic [15:0] dout,
  output logic      [15:0] stat,
  output logic      [15:0] din,
  // Bench controls
  input  wire logic        kick,
  input  wire logic [15:0] word,
  input  wire logic [5:0]  cond,
  output logic      [15:0] got
);
  logic [7:0] cnt_r;
  logic       flag_r;
  // Flag per word; host must answer before it self-clears
  always_ff @(posedge mclk or negedge resetn)
    if (!resetn)
    begin
      flag_r <= 1'b0;
      cnt_r <= 8'h00;
      got <= 16'h0000;
    end
    else if (kick)
    begin
      flag_r <= 1'b1;
      cnt_r <= 8'(FLAG_CYC);
    end
    else if (flag_r)
    begin
      cnt_r <= cnt_r - 8'h01;
      if (adrc[8] || cnt_r == 8'h01) flag_r <= 1'b0;
      if (adrc[11]) got <= ~dout;
    end
  // Only the chosen unit answers ready; bench sets the fault to seek-error bits and both mark bits
  assign stat = {cond[5:2], adrc[15:13] == UNIT_OK, cond[1:0], flag_r,
                 8'h01 << adrc[15:13]};
  // Word valid only while flagged, inverted otherwise
  assign din = flag_r ? word : ~word;
endmodule : dci_disk_model

/* verification/dci_host_props.sv */
// Port checker for the disk channel host controller
`timescale 1ns/100ps
module dci_host_props (
  // Clock and reset
  input wire logic        mclk,
  input wire logic        resetn,
  // Register port
  input wire logic [3:0]  sw_addr,
  input wire logic [15:0] sw_wdata,
  input wire logic        sw_wr,
  input wire logic        sw_rd,
  input wire logic [15:0] sw_rdata,
  // Channel words
  input wire logic [15:0] tag_select_output_channel,
  input wire logic [15:0] address_control_output_channel,
  input wire logic [15:0] disk_data_output_channel,
  input wire logic [15:0] disk_status_input_channel
);
  // Short names, the port names are too long for one line
  wire [15:0] tg = tag_select_output_channel;
  wire [15:0] ac = address_control_output_channel;
  wire [15:0] st = disk_status_input_channel;
  wire        wt = sw_wr && sw_addr == dci_pkg::REG_TAG;
  wire        wa = sw_wr && sw_addr == dci_pkg::REG_ADRC;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  // Output words against the register writes that cause them
  a_chsw_clear: assert property (tg[11:0] == 12'h000)
    else $error("channel switch bits set");
  a_tag_load:
    assert property (wt |=> tg[15:12] == $past(sw_wdata[15:12]))
    else $error("tag word not loaded");
  a_tag_hold: assert property (!wt |=> $stable(tg))
    else $error("tag word moved");
  a_adrc_load:
    assert property (wa |=> ac[15:9] == $past(sw_wdata[15:9]) && ac[7:0] == $past(sw_wdata[7:0]))
    else $error("address word not loaded");
  a_unit_hold: assert property (!wa |=> $stable(ac[15:13]))
    else $error("unit code moved");
  a_rstf_soft: assert property (wa && sw_wdata[8] |=> ac[8])
    else $error("reset flag not sent");
  a_rstf_short: assert property ($rose(ac[8]) |-> ##[1:2] !ac[8])
    else $error("reset flag too long");
  a_eng_pulse: assert property ($rose(ac[8]) && !$past(wa) |=> ac[8])
    else $error("engine pulse too short");
  a_read_ones: assert property (!ac[11] && !$past(ac[11]) |-> disk_data_output_channel == 16'hffff)
    else $error("data not all ones in read");
  a_rd_idle: assert property (!$past(sw_rd) |-> sw_rdata == 16'h0000)
    else $error("read data outside its cycle");
  a_stat_mirror:
    assert property ($stable(st) [*6] ##0 (sw_rd && sw_addr == dci_pkg::REG_STAT) |=> sw_rdata == $past(st))
    else $error("status not mirrored");
  // Main scenarios reached
  c_tag: cover property (wt);
  c_eng: cover property ($rose(ac[8]) && !$past(wa));
  c_rdat: cover property (sw_rd && sw_addr == dci_pkg::REG_RDATA);
endmodule : dci_host_props
bind dci_host dci_host_props dci_host_props_i (.*);

/* verification/test_dci_host.sv */
// Self-checking bench for the disk channel host controller
`timescale 1ns/100ps
module test_dci_host;
  logic        mclk, resetn, sw_wr, sw_rd, kick;
  logic [3:0]  sw_addr;
  logic [5:0]  cond;
  logic [15:0] sw_wdata, sw_rdata, tg, ac, dout, stat, din, word, got, q;
  int          errors, compares;
  dci_host dci_host_i (.mclk(mclk), .resetn(resetn), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
    .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .tag_select_output_channel(tg),
    .address_control_output_channel(ac), .disk_data_output_channel(dout),
    .disk_status_input_channel(stat), .disk_data_input_channel(din));
  dci_disk_model dci_disk_model_i (.mclk(mclk), .resetn(resetn), .adrc(ac), .dout(dout),
    .stat(stat), .din(din), .kick(kick), .word(word), .cond(cond), .got(got));
  // 25 MHz clock
  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    sw_wr <= 1'b1;
    sw_addr <= a;
    sw_wdata <= d;
    @(posedge mclk);
    sw_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    sw_rd <= 1'b1;
    sw_addr <= a;
    @(posedge mclk);
    sw_rd <= 1'b0;
    @(posedge mclk);
    q = sw_rdata;
  endtask : rd
  task automatic kick_flag();
    kick <= 1'b1;
    @(posedge mclk);
    kick <= 1'b0;
  endtask : kick_flag
  // Bounded poll of one engine bit; running out ends the run
  task automatic poll(input int b, input logic v);
    for (int n = 0; n < 60; n++)
    begin
      rd(dci_pkg::REG_ENG);
      if (q[b] === v) return;
    end
    errors++;
    report_and_stop();
  endtask : poll
  task automatic report_and_stop();
    $display("compares=%0d errors=%0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : report_and_stop
  // Main sequence
  initial
  begin
    {resetn, sw_wr, sw_rd, kick} = 4'h0;
    {sw_addr, cond} = 10'h000;
    sw_wdata = 16'h0000;
    word = 16'h3c5a;
    errors = 0;
    compares = 0;
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    repeat (3) @(posedge mclk);
    chk(tg, 16'h0000);
    chk(ac, 16'h0000);
    chk(dout, dci_pkg::ONES);
    $display("reset test done");
    for (int i = 12; i < 16; i++)
    begin
      wr(dci_pkg::REG_TAG, 16'h0fff | (16'h0001 << i));
      @(posedge mclk);
      chk(tg, 16'h0001 << i);
    end
    rd(dci_pkg::REG_TAG);
    chk(q, 16'h8000);
    cond <= 6'h24;
    wr(dci_pkg::REG_ADRC, 16'hb6c5);
    repeat (7) @(posedge mclk);
    chk(ac, 16'hb6c5);
    rd(dci_pkg::REG_STAT);
    chk(q, 16'h9820);
    wr(dci_pkg::REG_ADRC, 16'h2100);
    @(posedge mclk);
    chk(ac, 16'h2100);
    @(posedge mclk);
    chk(ac, 16'h2000);
    repeat (6) @(posedge mclk);
    rd(dci_pkg::REG_STAT);
    chk(q, 16'h9002);
    cond <= 6'h19;
    repeat (6) @(posedge mclk);
    rd(dci_pkg::REG_STAT);
    chk(q, 16'h6202);
    wr(4'hf, 16'hffff);
    rd(4'hf);
    chk(q, 16'h0000);
    $display("register test done");
    // Read word, then a second word before the first is taken
    wr(dci_pkg::REG_ENG, 16'h0001);
    kick_flag();
    poll(dci_pkg::ENG_RVAL, 1'b1);
    repeat (8) @(posedge mclk);
    chk({15'h0000, stat[8]}, 16'h0000);
    kick_flag();
    repeat (12) @(posedge mclk);
    rd(dci_pkg::REG_ENG);
    chk(q, 16'h000b);
    rd(dci_pkg::REG_RDATA);
    chk(q, word);
    wr(dci_pkg::REG_ENG, 16'h0009);
    rd(dci_pkg::REG_ENG);
    chk(q, 16'h0001);
    $display("read test done");
    wr(dci_pkg::REG_ADRC, 16'h2800);
    @(posedge mclk);
    wr(dci_pkg::REG_WDATA, 16'h1234);
    kick_flag();
    poll(dci_pkg::ENG_WPND, 1'b0);
    repeat (8) @(posedge mclk);
    chk(dout, 16'h1234);
    chk(got, 16'hedcb);
    wr(dci_pkg::REG_ADRC, 16'h2000);
    repeat (2) @(posedge mclk);
    chk(dout, dci_pkg::ONES);
    $display("write test done");
    // No flag for three times the window drops the arm
    repeat (500) @(posedge mclk);
    rd(dci_pkg::REG_ENG);
    chk(q, 16'h0010);
    $display("timeout test done");
    report_and_stop();
  end
endmodule : test_dci_host
